// *** gots_consts.vh ***
`ifndef GOTS_CONSTS_VH
`define GOTS_CONSTS_VH

// register offsets
`define GOTS_OFS_X_TC_HIGH    8'h04
`define GOTS_OFS_X_TC_LOW     8'h05
`define GOTS_OFS_Y_TC_HIGH    8'h07
`define GOTS_OFS_Y_TC_LOW     8'h08
`define GOTS_OFS_Z_TC_HIGH    8'h0a
`define GOTS_OFS_Z_TC_LOW     8'h0b
`define GOTS_OFS_ACCEL_X_ST   8'h0d
`define GOTS_OFS_ACCEL_Y_ST   8'h0e
`define GOTS_OFS_ACCEL_Z_ST   8'h0f

// storage slots, also the trim storage index
`define GOTS_IDX_X_HIGH       4'h0
`define GOTS_IDX_X_LOW        4'h1
`define GOTS_IDX_Y_HIGH       4'h2
`define GOTS_IDX_Y_LOW        4'h3
`define GOTS_IDX_Z_HIGH       4'h4
`define GOTS_IDX_Z_LOW        4'h5
`define GOTS_IDX_ACCEL_X      4'h6
`define GOTS_IDX_ACCEL_Y      4'h7
`define GOTS_IDX_ACCEL_Z      4'h8
`define GOTS_IDX_LAST         4'h8

// field positions in the high register
`define GOTS_LP_SHIFT_MSB     7
`define GOTS_LP_SHIFT_LSB     2
`define GOTS_TC_UPPER_MSB     1
`define GOTS_TC_UPPER_LSB     0

// reset values
`define GOTS_RST_BYTE         8'h00
`define GOTS_RST_OFFSET       32'h0000_0000

// correction step, 2.52 mdps per degree C, in units of 0.01 mdps
`define GOTS_TC_STEP_CENTI    10'h0fc

`endif

// *** gots_tc_axis.v ***
`default_nettype none
`include "gots_consts.vh"

module gots_tc_axis (
   input  wire               mclk,
   input  wire               rst_n,
   input  wire        [9:0]  tc_coeff,
   input  wire        [7:0]  temp_delta,
   input  wire        [31:0] offset_in,
   output reg         [31:0] offset_out_r
);

   wire signed [17:0] coeff_x_temp;
   wire signed [27:0] correction;
   wire        [31:0] offset_nxt;

   // coefficient times temperature delta times step size
   assign coeff_x_temp = $signed(tc_coeff) * $signed(temp_delta);                 // [RULE6]
   assign correction   = coeff_x_temp * $signed(`GOTS_TC_STEP_CENTI);             // [RULE6]
   // zero coefficient gives zero correction, offset passes unaltered
   assign offset_nxt   = offset_in + {{4{correction[27]}}, correction};           // [RULE5]

   always @(posedge mclk) begin
      if (!rst_n) begin
         offset_out_r <= `GOTS_RST_OFFSET;
      end else begin
         offset_out_r <= offset_nxt;                                              // [RULE3]
      end
   end

endmodule // gots_tc_axis
`default_nettype wire

// *** gots_trim_regs.v ***
// Overview of operation
// [RULE1] high register bits 7:2 hold low-power shift
// [RULE2] ten-bit coefficient: high bits 1:0, low byte
// [RULE3] compensation always applied, no enable
// [RULE4] reload trimmed coefficients on reset or command
// [RULE5] zero coefficient leaves offset unaltered
// [RULE6] step is 2.52 mdps per degree C
// [RULE7] host writes hold until next reset; a full_reset_req reload also overwrites them with trim
// [RULE8] same behaviour for x, y, z pairs
// [RULE9] three accel self-test codes at 0x0d-0x0f
// [RULE10] host converts code to expected response
// [RULE11] self-test codes also reloaded from trim
`default_nettype none
`include "gots_consts.vh"

module gots_trim_regs (
   input  wire               mclk,
   input  wire               rst_n,
   input  wire        [7:0]  reg_addr,
   input  wire               reg_wr,
   input  wire               reg_rd,
   input  wire        [7:0]  reg_wdata,
   output reg         [7:0]  reg_rdata_r,
   output reg                reg_rvalid_r,
   input  wire               full_reset_req,
   output reg                trim_rd_r,
   output reg         [3:0]  trim_index_r,
   input  wire        [7:0]  trim_data,
   output reg                load_busy_r,
   input  wire        [7:0]  temp_delta,
   input  wire        [31:0] gyro_x_offset_in,
   input  wire        [31:0] gyro_y_offset_in,
   input  wire        [31:0] gyro_z_offset_in,
   output wire        [31:0] gyro_x_comp_r,
   output wire        [31:0] gyro_y_comp_r,
   output wire        [31:0] gyro_z_comp_r
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_REQ  = 2'b01;
   localparam [1:0] ST_CAPT = 2'b10;

   reg  [7:0] store_r [0:8];
   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   wire [4:0] wr_map;
   wire [4:0] rd_map;
   wire       wr_ok;
   integer    i;

   // offset to slot; bit 4 marks a mapped offset
   function [4:0] slot_of;
      input [7:0] ofs;
      begin
         case (ofs)
            `GOTS_OFS_X_TC_HIGH:  slot_of = {1'b1, `GOTS_IDX_X_HIGH};             // [RULE8]
            `GOTS_OFS_X_TC_LOW:   slot_of = {1'b1, `GOTS_IDX_X_LOW};
            `GOTS_OFS_Y_TC_HIGH:  slot_of = {1'b1, `GOTS_IDX_Y_HIGH};
            `GOTS_OFS_Y_TC_LOW:   slot_of = {1'b1, `GOTS_IDX_Y_LOW};
            `GOTS_OFS_Z_TC_HIGH:  slot_of = {1'b1, `GOTS_IDX_Z_HIGH};
            `GOTS_OFS_Z_TC_LOW:   slot_of = {1'b1, `GOTS_IDX_Z_LOW};
            `GOTS_OFS_ACCEL_X_ST: slot_of = {1'b1, `GOTS_IDX_ACCEL_X};            // [RULE9]
            `GOTS_OFS_ACCEL_Y_ST: slot_of = {1'b1, `GOTS_IDX_ACCEL_Y};
            `GOTS_OFS_ACCEL_Z_ST: slot_of = {1'b1, `GOTS_IDX_ACCEL_Z};
            default:              slot_of = 5'h00;
         endcase
      end
   endfunction

   // ten-bit coefficient from a high/low pair
   function [9:0] coeff_of;
      input [7:0] high_byte;
      input [7:0] low_byte;
      begin
         coeff_of = {high_byte[`GOTS_TC_UPPER_MSB:`GOTS_TC_UPPER_LSB], low_byte}; // [RULE2]
      end
   endfunction

   assign wr_map = slot_of(reg_addr);
   assign rd_map = slot_of(reg_addr);
   // writes are dropped while trim is loading or a reload is asked for
   assign wr_ok  = reg_wr && wr_map[4] && (state_r == ST_IDLE) && !full_reset_req;

   // trim load sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (full_reset_req) begin
               state_nxt = ST_REQ;                                                // [RULE4]
            end
         end
         ST_REQ: begin
            state_nxt = ST_CAPT;
         end
         ST_CAPT: begin
            if (trim_index_r == `GOTS_IDX_LAST) begin
               state_nxt = ST_IDLE;
            end else begin
               state_nxt = ST_REQ;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         state_r      <= ST_REQ;                                                  // [RULE4]
         trim_index_r <= 4'h0;
         // boot load starts in ST_REQ, so the request already stands
         trim_rd_r    <= 1'b1;                                                    // [RULE4]
         load_busy_r  <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         trim_rd_r   <= (state_nxt == ST_REQ);
         load_busy_r <= (state_nxt != ST_IDLE);
         if (state_r == ST_IDLE) begin
            trim_index_r <= 4'h0;
         end else if (state_r == ST_CAPT && trim_index_r != `GOTS_IDX_LAST) begin
            trim_index_r <= trim_index_r + 4'h1;
         end
      end
   end

   // register storage: trim copy or host write
   always @(posedge mclk) begin
      if (!rst_n) begin
         for (i = 0; i < 9; i = i + 1) begin
            store_r[i] <= `GOTS_RST_BYTE;
         end
      end else if (state_r == ST_CAPT) begin
         store_r[trim_index_r] <= trim_data;                                      // [RULE4] [RULE11]
      end else if (wr_ok) begin
         // lp shift bits just stored for software
         store_r[wr_map[3:0]] <= reg_wdata;                                       // [RULE7] [RULE1]
      end
   end

   // read port, unmapped offsets read zero
   always @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata_r  <= `GOTS_RST_BYTE;
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
         if (reg_rd) begin
            reg_rdata_r <= rd_map[4] ? store_r[rd_map[3:0]] : `GOTS_RST_BYTE;    // [RULE9]
         end
      end
   end

   // per-axis compensation, always active from current contents
   gots_tc_axis u_axis_x (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .tc_coeff     (coeff_of(store_r[`GOTS_IDX_X_HIGH], store_r[`GOTS_IDX_X_LOW])), // [RULE3]
      .temp_delta   (temp_delta),
      .offset_in    (gyro_x_offset_in),
      .offset_out_r (gyro_x_comp_r)
   );

   gots_tc_axis u_axis_y (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .tc_coeff     (coeff_of(store_r[`GOTS_IDX_Y_HIGH], store_r[`GOTS_IDX_Y_LOW])), // [RULE8]
      .temp_delta   (temp_delta),
      .offset_in    (gyro_y_offset_in),
      .offset_out_r (gyro_y_comp_r)
   );

   gots_tc_axis u_axis_z (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .tc_coeff     (coeff_of(store_r[`GOTS_IDX_Z_HIGH], store_r[`GOTS_IDX_Z_LOW])), // [RULE8]
      .temp_delta   (temp_delta),
      .offset_in    (gyro_z_offset_in),
      .offset_out_r (gyro_z_comp_r)
   );

endmodule // gots_trim_regs
`default_nettype wire

// *** gots_trim_regs_note_end.v ***
`default_nettype none
`default_nettype wire

// *** gots_trim_model.sv ***
`default_nettype none
module gots_trim_model (
   input  wire logic       mclk,
   input  wire logic       trim_rd_r,
   input  wire logic [3:0] trim_index_r,
   output var  logic [7:0] trim_data
);
   timeunit 1ns / 1ps;
   logic [7:0] junk_r = 8'h0;
   logic       hold_r = 1'b0;
   always @(posedge mclk) {hold_r, junk_r} <= {trim_rd_r, junk_r + 8'h3b};
   // trim byte while asked and one cycle on, else churn
   // codes never zero, host takes code minus one
   always_comb trim_data = (trim_rd_r | hold_r) ? 8'h31 + 8'h17 * trim_index_r : junk_r;
endmodule // gots_trim_model
`default_nettype wire

// *** gots_trim_regs_checker.sv ***
`default_nettype none
module gots_chk (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic       reg_rvalid_r,
   input wire logic       full_reset_req,
   input wire logic       trim_rd_r,
   input wire logic [3:0] trim_index_r,
   input wire logic       load_busy_r
);
   timeunit 1ns / 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_RD: assert property (reg_rd |=> reg_rvalid_r)
      else $error("no read valid");
   AST_NORD: assert property (!reg_rd |=> !reg_rvalid_r)
      else $error("stray read valid");
   AST_RDHOLD: assert property (!reg_rd |=> $stable(reg_rdata_r))
      else $error("read data moved");
   AST_UNMAP: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata_r == 8'h00)
      else $error("unmapped read");
   AST_LOADGO: assert property (full_reset_req && !load_busy_r |=>
      load_busy_r && trim_rd_r && trim_index_r == 4'h0) else $error("load not started");
   AST_LOADLEN: assert property (full_reset_req && !load_busy_r |->
      ##18 load_busy_r ##1 !load_busy_r) else $error("load length");
   AST_TRIMPULSE: assert property (trim_rd_r |=> !trim_rd_r)
      else $error("trim request long");
   AST_TRIMSEQ: assert property (trim_rd_r && trim_index_r != 4'h8 |=> ##1
      trim_rd_r && trim_index_r == $past(trim_index_r, 2) + 4'h1) else $error("trim order");
endmodule // gots_chk
bind gots_trim_regs gots_chk u_gots_chk (.*);
`default_nettype wire

// *** tb.sv ***
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module tb;
   timeunit 1ns / 1ps;
   logic        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, full_reset_req = 1'b0;
   logic [7:0]  reg_addr = 8'h0, reg_wdata = 8'h0, temp_delta = 8'h0, reg_rdata_r, trim_data;
   logic [31:0] gyro_x_offset_in = 32'h0, gyro_y_offset_in = 32'h0, gyro_z_offset_in = 32'h0;
   logic [31:0] gyro_x_comp_r, gyro_y_comp_r, gyro_z_comp_r, o [3];
   logic        reg_rvalid_r, trim_rd_r, load_busy_r;
   logic [3:0]  trim_index_r;
   logic [7:0]  ad [9] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h0f};
   int          err_count = 0, cmp_count = 0, m [9];
   gots_trim_regs  u_gots_trim_regs (.*);
   gots_trim_model u_gots_trim_model (.*);
   always #12.5 mclk = ~mclk;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(posedge mclk) #2 reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input int e);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(posedge mclk) #2 reg_rd = 1'b0;
      `CHK({reg_rvalid_r, reg_rdata_r}, {1'b1, e[7:0]})
      @(posedge mclk) #2;
   endtask
   task automatic trim_chk();
      for (int i = 0; i < 9; i++) begin
         m[i] = (8'h31 + 8'h17 * i) & 8'hff;
         rd(ad[i], m[i]);
      end
   endtask
   task automatic comp(input int t);
      int c;
      o = '{$urandom, $urandom, $urandom};
      {gyro_x_offset_in, gyro_y_offset_in, gyro_z_offset_in} = {o[0], o[1], o[2]};
      temp_delta = t[7:0];
      repeat (2) @(posedge mclk) #2;
      for (int i = 0; i < 3; i++) begin
         c = $signed({m[2*i][1:0], m[2*i+1][7:0]});
         o[i] += c * t * 252;
      end
      `CHK({gyro_x_comp_r, gyro_y_comp_r, gyro_z_comp_r}, {o[0], o[1], o[2]})
   endtask
   task automatic summarize();
      if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      void'($urandom(7));
      repeat (4) @(posedge mclk) #2;
      rst_n = 1'b1;
      repeat (20) @(posedge mclk) #2;
      trim_chk();
      comp($urandom_range(255) - 128);
      for (int i = 0; i < 9; i++) begin
         m[i] = $urandom_range(255);
         wr(ad[i], m[i]);
         rd(ad[i], m[i]);
      end
      comp(-128);
      comp(0);
      for (int i = 0; i < 2; i++) begin
         wr(ad[i], 8'h00);
         @(posedge mclk) #2;
      end
      m[0:1] = '{0, 0};
      comp(127);
      wr(8'h06, 8'h5a);
      rd(8'h06, 0);
      full_reset_req = 1'b1;
      @(posedge mclk) #2 full_reset_req = 1'b0;
      `CHK(load_busy_r, 1'b1)
      repeat (4) @(posedge mclk) #2;
      wr(8'h04, 8'ha5);
      repeat (16) @(posedge mclk) #2;
      `CHK(load_busy_r, 1'b0)
      trim_chk();
      summarize();
   end
   initial begin
      #50us err_count++;
      summarize();
   end
endmodule // tb
`default_nettype wire
